// ---- core/pwrctl_top.sv ----
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/10ps
module pwrctl_top (
	input wire logic ref_clk, // Core clock, 250 MHz.
	input wire logic reset_n, // Any reset, asynchronous, active low.
	input wire logic por_n, // Power-on reset only, asynchronous, active low.
	input wire logic [pwrctl_pkg::ADDR_W-1:0] address, // Avalon byte address.
	input wire logic read, // Avalon read.
	input wire logic write, // Avalon write.
	input wire logic [3:0] byteenable, // Avalon byte enables.
	input wire logic [pwrctl_pkg::DATA_W-1:0] writedata, // Avalon write data.
	output logic [pwrctl_pkg::DATA_W-1:0] readdata, // Avalon read data.
	output logic waitrequest, // Avalon wait.
	input wire logic irq_taken, // Core accepted an interrupt, pulse.
	input wire logic serial_mode_bit_0, // Serial control mode bit.
	input wire logic framing_error_flag, // Serial framing error.
	output logic serial_control_top, // Top bit view of serial control.
	output logic baud_doubler, // Double baud rate in modes 1 to 3.
	output logic frame_error_view_select, // Top bit shows framing error.
	output logic idle_request, // Core in idle.
	output logic power_down_request, // Core in power-down.
	output logic cold_start_flag, // Set by power-on reset; warm resets keep it.
	output logic irq // Level interrupt.
);
	// -------------------------------------------------------------------
	// Reset and bus decode
	// -------------------------------------------------------------------
	// A power-on reset is also a reset of everything else.
	logic sys_rst_n;
	logic req;
	logic done;
	logic pc_write;
	logic [7:0] pc_value;
	logic next_idle;
	logic next_pd;
	logic [7:0] next_rdata;
	logic user_flag_0;
	logic user_flag_1;

	assign sys_rst_n = reset_n & por_n;
	assign req = read | write;
	assign done = req & ~waitrequest;

	function automatic logic hit(input logic [pwrctl_pkg::ADDR_W-1:0] a,
			input logic [pwrctl_pkg::ADDR_W-1:0] reg_addr);
		hit = (a == reg_addr);
	endfunction : hit

	assign pc_write = done & write & byteenable[0] & hit(address, pwrctl_pkg::PWR_CTRL_ADDR);

	pwrctl_evt_if evt ();

	pwrctl_irq u_irq (
		.ref_clk(ref_clk),
		.reset_n(sys_rst_n),
		.ev(evt.irq),
		.irq(irq)
	);

	// -------------------------------------------------------------------
	// Bus handshake
	// -------------------------------------------------------------------
	// Each access is answered one cycle after it is raised; the low cycle is
	// the completion, after which waitrequest goes high again.
	always_ff @(posedge ref_clk or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			waitrequest <= 1'b1;
		end else begin
			waitrequest <= ~(req & waitrequest);
		end
	end

	always_comb begin
		next_rdata = 8'h00;
		if (hit(address, pwrctl_pkg::PWR_CTRL_ADDR)) begin
			next_rdata = pc_value;
		end else if (hit(address, pwrctl_pkg::IRQ_STATUS_ADDR)) begin
			next_rdata = {5'h00, evt.status};
		end else if (hit(address, pwrctl_pkg::IRQ_MASK_ADDR)) begin
			next_rdata = {5'h00, evt.mask};
		end else begin
			next_rdata = 8'h00;
		end
	end

	// Read data is captured as waitrequest falls and stands through completion.
	always_ff @(posedge ref_clk or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			readdata <= '0;
		end else if (read & waitrequest) begin
			readdata <= {24'h000000, next_rdata};
		end
	end

	// -------------------------------------------------------------------
	// Power control register
	// -------------------------------------------------------------------
	always_comb begin
		pc_value = 8'h00;
		pc_value[pwrctl_pkg::BIT_BAUD] = baud_doubler;
		pc_value[pwrctl_pkg::BIT_FEV] = frame_error_view_select;
		pc_value[pwrctl_pkg::BIT_COLD] = cold_start_flag;
		pc_value[pwrctl_pkg::BIT_UF1] = user_flag_1;
		pc_value[pwrctl_pkg::BIT_UF0] = user_flag_0;
		pc_value[pwrctl_pkg::BIT_PD] = power_down_request;
		pc_value[pwrctl_pkg::BIT_IDLE] = idle_request;
	end

	always_comb begin
		next_idle = idle_request;
		next_pd = power_down_request;
		if (pc_write) begin
			next_idle = writedata[pwrctl_pkg::BIT_IDLE];
			next_pd = writedata[pwrctl_pkg::BIT_PD];
		end
		if (irq_taken) begin
			next_idle = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			idle_request <= pwrctl_pkg::PWR_CTRL_RESET[pwrctl_pkg::BIT_IDLE];
		end else begin
			idle_request <= next_idle;
		end
	end

	always_ff @(posedge ref_clk or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			power_down_request <= pwrctl_pkg::PWR_CTRL_RESET[pwrctl_pkg::BIT_PD];
		end else begin
			power_down_request <= next_pd;
		end
	end

	always_ff @(posedge ref_clk or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			baud_doubler <= pwrctl_pkg::PWR_CTRL_RESET[pwrctl_pkg::BIT_BAUD];
		end else if (pc_write) begin
			baud_doubler <= writedata[pwrctl_pkg::BIT_BAUD];
		end
	end

	always_ff @(posedge ref_clk or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			frame_error_view_select <= pwrctl_pkg::PWR_CTRL_RESET[pwrctl_pkg::BIT_FEV];
		end else if (pc_write) begin
			frame_error_view_select <= writedata[pwrctl_pkg::BIT_FEV];
		end
	end

	always_ff @(posedge ref_clk or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			user_flag_0 <= pwrctl_pkg::PWR_CTRL_RESET[pwrctl_pkg::BIT_UF0];
			user_flag_1 <= pwrctl_pkg::PWR_CTRL_RESET[pwrctl_pkg::BIT_UF1];
		end else if (pc_write) begin
			user_flag_0 <= writedata[pwrctl_pkg::BIT_UF0];
			user_flag_1 <= writedata[pwrctl_pkg::BIT_UF1];
		end
	end

	// The flag sees only the power-on reset, so warm resets keep it for
	// software to inspect afterwards.
	// power-on only
	always_ff @(posedge ref_clk or negedge por_n) begin
		if (!por_n) begin
			cold_start_flag <= pwrctl_pkg::PWR_CTRL_RESET[pwrctl_pkg::BIT_COLD];
		end else if (pc_write) begin
			cold_start_flag <= writedata[pwrctl_pkg::BIT_COLD];
		end
	end

	// Registered so the output comes from a flop; it lags its inputs by a cycle.
	// top bit mux
	always_ff @(posedge ref_clk or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			serial_control_top <= 1'b0;
		end else begin
			serial_control_top <= frame_error_view_select ? framing_error_flag : serial_mode_bit_0;
		end
	end

	// -------------------------------------------------------------------
	// Interrupt events
	// -------------------------------------------------------------------
	always_comb begin
		evt.event_set = pwrctl_pkg::EVT_NONE;
		evt.event_set[pwrctl_pkg::EV_IDLE_ENTER] = next_idle & ~idle_request;
		evt.event_set[pwrctl_pkg::EV_IDLE_EXIT] = idle_request & irq_taken;
		evt.event_set[pwrctl_pkg::EV_PD_ENTER] = next_pd & ~power_down_request;
		evt.status_clr = pwrctl_pkg::EVT_NONE;
		// Only the bits that were returned are cleared, so a late event survives.
		if (done & read & hit(address, pwrctl_pkg::IRQ_STATUS_ADDR)) begin
			evt.status_clr = readdata[pwrctl_pkg::EVT_W-1:0];
		end
		evt.mask_wr = done & write & byteenable[0] & hit(address, pwrctl_pkg::IRQ_MASK_ADDR);
		evt.mask_wdata = writedata[pwrctl_pkg::EVT_W-1:0];
	end

	// -------------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!sys_rst_n);

	sequence s_pc_write;
		write && !waitrequest && byteenable[0] && address == pwrctl_pkg::PWR_CTRL_ADDR;
	endsequence

	sequence s_pc_read_done;
		read && !waitrequest && address == pwrctl_pkg::PWR_CTRL_ADDR;
	endsequence

	a_bus_one_wait: assert property (req && waitrequest |=> !waitrequest)
		else $error("access not answered after one wait cycle");

	a_pd_write_set: assert property (s_pc_write ##0 writedata[pwrctl_pkg::BIT_PD]
			|=> power_down_request)
		else $error("power-down bit not set by write");

	a_pd_hold: assert property (!pc_write |=> power_down_request == $past(power_down_request))
		else $error("power-down bit changed without a write");

	a_idle_irq_exit: assert property (idle_request && irq_taken |=> !idle_request)
		else $error("taken interrupt did not end idle");

	a_idle_write_set: assert property (s_pc_write ##0 writedata[pwrctl_pkg::BIT_IDLE]
			&& !irq_taken |=> idle_request)
		else $error("idle bit not set by write");

	a_baud_follow: assert property (s_pc_write
			|=> baud_doubler == $past(writedata[pwrctl_pkg::BIT_BAUD]))
		else $error("baud doubler does not follow written bit");

	a_view_mux: assert property (frame_error_view_select && framing_error_flag
			&& !pc_write |=> serial_control_top)
		else $error("top bit view does not show framing error");

	a_rsvd_reads_zero: assert property (s_pc_read_done
			|-> readdata[pwrctl_pkg::BIT_RSVD] == 1'b0)
		else $error("reserved bit read back non-zero");

	a_user_flags: assert property (s_pc_write |=> ##1 {user_flag_1, user_flag_0}
			== $past(writedata[pwrctl_pkg::BIT_UF1:pwrctl_pkg::BIT_UF0], 2))
		else $error("user flags not stored");

	a_cold_keep: assert property (@(posedge ref_clk) disable iff (!por_n)
			!pc_write |=> $stable(cold_start_flag))
		else $error("cold-start flag changed without write or power-on");

	a_warm_reset_clears: assert property (@(posedge ref_clk) disable iff (!por_n)
			$rose(reset_n) |-> !power_down_request && !idle_request)
		else $error("mode bits not cleared by reset");

	a_readback_value: assert property (s_pc_read_done |-> readdata[7:0]
			== (pc_value & 8'hDF) || $past(pc_write))
		else $error("power control read back wrong");

	// -------------------------------------------------------------------
	// Field isolation and bus timing checks
	// -------------------------------------------------------------------
	// A write with lane 0 off must leave every field alone; a leak here would
	// let a wider master corrupt the register through an upper byte.
	sequence s_pc_lane_off;
		write && !waitrequest && !byteenable[0] && address == pwrctl_pkg::PWR_CTRL_ADDR;
	endsequence

	a_pd_write_clear: assert property (s_pc_write ##0 !writedata[pwrctl_pkg::BIT_PD]
			|=> !power_down_request)
		else $error("power-down bit not cleared by write");

	a_idle_write_clear: assert property (s_pc_write ##0 !writedata[pwrctl_pkg::BIT_IDLE]
			|=> !idle_request)
		else $error("idle bit not cleared by write");

	// The interrupt clear wins over a software set landing in the same cycle.
	a_irq_beats_write: assert property (s_pc_write ##0 irq_taken |=> !idle_request)
		else $error("software set of idle beat a taken interrupt");

	a_baud_hold: assert property (!pc_write |=> $stable(baud_doubler))
		else $error("baud doubler changed without a write");

	a_fev_follow: assert property (s_pc_write
			|=> frame_error_view_select == $past(writedata[pwrctl_pkg::BIT_FEV]))
		else $error("view select does not follow written bit");

	a_fev_hold: assert property (!pc_write |=> $stable(frame_error_view_select))
		else $error("view select changed without a write");

	a_view_mode: assert property (!frame_error_view_select
			|=> serial_control_top == $past(serial_mode_bit_0))
		else $error("top bit view does not show the mode bit");

	a_user_hold: assert property (!pc_write |=> $stable({user_flag_1, user_flag_0}))
		else $error("user flags changed without a write");

	a_cold_write: assert property (s_pc_write
			|=> cold_start_flag == $past(writedata[pwrctl_pkg::BIT_COLD]))
		else $error("cold-start flag does not follow written bit");

	a_cold_por: assert property ($rose(por_n) |-> cold_start_flag)
		else $error("cold-start flag not set by power-on");

	a_lane_off_ignored: assert property (s_pc_lane_off ##0 !irq_taken
			|=> $stable(pc_value))
		else $error("write without lane 0 changed the register");

	// Completion is a single cycle, so the next request always sees a wait first.
	a_wait_after_done: assert property (done |=> waitrequest)
		else $error("waitrequest stayed low after completion");

	a_readdata_hold: assert property (!(read && waitrequest) |=> $stable(readdata))
		else $error("read data moved outside a read");
endmodule : pwrctl_top

// ---- core/pwrctl_pkg.sv ----
package pwrctl_pkg;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int EVT_W = 3;
	// -------------------------------------------------------------------
	// Register indices; the byte address is four times the index.
	// -------------------------------------------------------------------
	localparam logic [7:0] PWR_CTRL_IDX = 8'h87;
	localparam logic [7:0] IRQ_STATUS_IDX = 8'h88;
	localparam logic [7:0] IRQ_MASK_IDX = 8'h89;
	localparam logic [ADDR_W-1:0] PWR_CTRL_ADDR = {PWR_CTRL_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = {IRQ_STATUS_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX, 2'h0};
	// -------------------------------------------------------------------
	// Field positions and reset values.
	// -------------------------------------------------------------------
	localparam int BIT_IDLE = 0;
	localparam int BIT_PD = 1;
	localparam int BIT_UF0 = 2;
	localparam int BIT_UF1 = 3;
	localparam int BIT_COLD = 4;
	localparam int BIT_RSVD = 5;
	localparam int BIT_FEV = 6;
	localparam int BIT_BAUD = 7;
	localparam logic [7:0] PWR_CTRL_RESET = 8'h10;
	localparam int EV_IDLE_ENTER = 0;
	localparam int EV_IDLE_EXIT = 1;
	localparam int EV_PD_ENTER = 2;
	localparam logic [EVT_W-1:0] EVT_NONE = 3'h0;
endpackage : pwrctl_pkg

// ---- core/pwrctl_evt_if.sv ----
`timescale 1ns/10ps
interface pwrctl_evt_if;
	logic [pwrctl_pkg::EVT_W-1:0] event_set;
	logic [pwrctl_pkg::EVT_W-1:0] status_clr;
	logic mask_wr;
	logic [pwrctl_pkg::EVT_W-1:0] mask_wdata;
	logic [pwrctl_pkg::EVT_W-1:0] status;
	logic [pwrctl_pkg::EVT_W-1:0] mask;
	modport core (output event_set, status_clr, mask_wr, mask_wdata, input status, mask);
	modport irq (input event_set, status_clr, mask_wr, mask_wdata, output status, mask);
endinterface : pwrctl_evt_if

// ---- core/pwrctl_irq.sv ----
`timescale 1ns/10ps
module pwrctl_irq (
	input wire logic ref_clk, // Core clock.
	input wire logic reset_n, // Asynchronous reset, active low.
	pwrctl_evt_if.irq ev, // Events, clears and mask access.
	output logic irq // Level interrupt.
);
	logic [pwrctl_pkg::EVT_W-1:0] next_status;
	logic [pwrctl_pkg::EVT_W-1:0] next_mask;

	// A new event wins over a read-clear landing in the same cycle.
	always_comb begin
		next_status = (ev.status & ~ev.status_clr) | ev.event_set;
		next_mask = ev.mask_wr ? ev.mask_wdata : ev.mask;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ev.status <= pwrctl_pkg::EVT_NONE;
		end else begin
			ev.status <= next_status;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ev.mask <= pwrctl_pkg::EVT_NONE;
		end else begin
			ev.mask <= next_mask;
		end
	end

	// Computed from next values so the line rises with the status bit.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_status & next_mask);
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	a_irq_level_match: assert property (irq == |(ev.status & ev.mask))
		else $error("interrupt line disagrees with masked status");

	// An unmasked event must raise the line on the very next edge, even when a
	// read-clear of the same status word lands in that cycle.
	a_irq_event_rise: assert property (|(ev.event_set & ev.mask) && !ev.mask_wr |=> irq)
		else $error("unmasked event did not raise the interrupt");
endmodule : pwrctl_irq

// ---- bench/pwrctl_top_tb.sv ----
`timescale 1ns/10ps
module pwrctl_top_tb;
	logic ref_clk, reset_n, por_n, read, write, irq_taken, serial_mode_bit_0, framing_error_flag;
	logic [pwrctl_pkg::ADDR_W-1:0] address;
	logic [3:0] byteenable;
	logic [pwrctl_pkg::DATA_W-1:0] writedata, readdata;
	logic waitrequest, serial_control_top, baud_doubler, frame_error_view_select;
	logic idle_request, power_down_request, cold_start_flag, irq;
	logic [31:0] rd;
	int num_errors = 0;
	int check_count = 0;

	pwrctl_top uut (
		.ref_clk(ref_clk), .reset_n(reset_n), .por_n(por_n), .address(address), .read(read),
		.write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .irq_taken(irq_taken), .serial_mode_bit_0(serial_mode_bit_0),
		.framing_error_flag(framing_error_flag), .serial_control_top(serial_control_top),
		.baud_doubler(baud_doubler), .frame_error_view_select(frame_error_view_select),
		.idle_request(idle_request), .power_down_request(power_down_request),
		.cold_start_flag(cold_start_flag), .irq(irq)
	);

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// -------------------------------------------------------------------
	// Shared bus and comparison tasks.
	// -------------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// The request is held until the edge that samples waitrequest low; only then released.
	task automatic bus_op(input logic wr, input logic [9:0] a, input logic [7:0] d,
			input logic [3:0] be, output logic [31:0] q);
		address <= a;
		writedata <= {24'h000000, d};
		byteenable <= be;
		write <= wr;
		read <= ~wr;
		do begin
			@(posedge ref_clk);
		end while (waitrequest !== 1'b0);
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
		// One edge passes so a following call never drives the strobes twice in a step.
		@(posedge ref_clk);
	endtask : bus_op

	task automatic bus_write(input logic [9:0] a, input logic [7:0] d, input logic [3:0] be);
		logic [31:0] q;
		bus_op(1'b1, a, d, be, q);
	endtask : bus_write

	task automatic bus_read(input logic [9:0] a, output logic [31:0] q);
		bus_op(1'b0, a, 8'h00, 4'hF, q);
	endtask : bus_read

	task automatic pulse_reset(input logic por);
		reset_n <= 1'b0;
		if (por) begin
			por_n <= 1'b0;
		end
		tick(3);
		reset_n <= 1'b1;
		por_n <= 1'b1;
		tick(2);
	endtask : pulse_reset

	// -------------------------------------------------------------------
	// Scenarios.
	// -------------------------------------------------------------------
	task automatic test_reset_values();
		bus_read(pwrctl_pkg::PWR_CTRL_ADDR, rd);
		chk(rd & 32'hFFFFFFDF, {24'h000000, pwrctl_pkg::PWR_CTRL_RESET}, "reset value");
		chk(32'({baud_doubler, frame_error_view_select, idle_request, power_down_request}),
			32'h0, "mode outputs after reset");
		chk(32'(cold_start_flag), 32'h1, "cold flag after power-on");
		$display("test reset_values done");
	endtask : test_reset_values

	task automatic test_flags();
		bus_write(pwrctl_pkg::PWR_CTRL_ADDR, 8'hCC, 4'h1); // bit 5 left clear
		tick(1);
		chk(32'({baud_doubler, frame_error_view_select, cold_start_flag}), 32'h6, "mode bits");
		bus_read(pwrctl_pkg::PWR_CTRL_ADDR, rd);
		chk(rd & 32'hFFFFFFDF, 32'hCC, "user flags readback");
		bus_write(pwrctl_pkg::PWR_CTRL_ADDR, 8'h10, 4'h1);
		tick(1);
		chk(32'(cold_start_flag), 32'h1, "cold flag set by software");
		$display("test flags done");
	endtask : test_flags

	task automatic test_serial_view();
		bus_write(pwrctl_pkg::PWR_CTRL_ADDR, 8'h00, 4'h1);
		serial_mode_bit_0 <= 1'b1;
		framing_error_flag <= 1'b0;
		tick(2);
		chk(32'(serial_control_top), 32'h1, "view shows mode bit");
		bus_write(pwrctl_pkg::PWR_CTRL_ADDR, 8'h40, 4'h1);
		tick(2);
		chk(32'(serial_control_top), 32'h0, "view shows framing error");
		framing_error_flag <= 1'b1;
		tick(2);
		chk(32'(serial_control_top), 32'h1, "view follows framing error");
		$display("test serial_view done");
	endtask : test_serial_view

	task automatic test_resets();
		bus_write(pwrctl_pkg::PWR_CTRL_ADDR, 8'h12, 4'h1);
		tick(1);
		chk(32'({power_down_request, cold_start_flag}), 32'h3, "power-down entered");
		pulse_reset(1'b0);
		chk(32'({power_down_request, cold_start_flag}), 32'h1, "warm reset keeps flag");
		bus_write(pwrctl_pkg::PWR_CTRL_ADDR, 8'h02, 4'h1);
		pulse_reset(1'b0);
		chk(32'({power_down_request, cold_start_flag}), 32'h0, "cleared flag survives");
		pulse_reset(1'b1);
		chk(32'({power_down_request, cold_start_flag}), 32'h1, "power-on sets flag");
		$display("test resets done");
	endtask : test_resets

	task automatic test_idle_irq();
		bus_write(pwrctl_pkg::IRQ_MASK_ADDR, 8'h07, 4'h1);
		bus_write(pwrctl_pkg::PWR_CTRL_ADDR, 8'h01, 4'h1);
		tick(1);
		chk(32'({idle_request, irq}), 32'h3, "idle entered with interrupt");
		bus_read(pwrctl_pkg::IRQ_STATUS_ADDR, rd);
		chk(rd, 32'h1, "idle entry status");
		tick(1);
		chk(32'(irq), 32'h0, "status read clears interrupt");
		irq_taken <= 1'b1;
		tick(1);
		irq_taken <= 1'b0;
		tick(1);
		chk(32'({idle_request, irq}), 32'h1, "taken interrupt ends idle");
		bus_read(pwrctl_pkg::IRQ_STATUS_ADDR, rd);
		chk(rd, 32'h2, "idle exit status");
		bus_write(pwrctl_pkg::IRQ_MASK_ADDR, 8'h03, 4'h1);
		bus_write(pwrctl_pkg::PWR_CTRL_ADDR, 8'h02, 4'h1);
		tick(1);
		chk(32'({power_down_request, irq}), 32'h2, "masked power-down event");
		bus_read(pwrctl_pkg::IRQ_STATUS_ADDR, rd);
		chk(rd, 32'h4, "power-down status");
		pulse_reset(1'b0);
		chk(32'(power_down_request), 32'h0, "reset leaves power-down");
		$display("test idle_irq done");
	endtask : test_idle_irq

	task automatic test_refused();
		bus_write(pwrctl_pkg::PWR_CTRL_ADDR, 8'h0C, 4'h0);
		bus_read(pwrctl_pkg::PWR_CTRL_ADDR, rd);
		chk(rd & 32'hFFFFFFDF, 32'h0, "partial write ignored");
		bus_write(10'h3FC, 8'hFF, 4'h1);
		bus_read(10'h3FC, rd);
		chk(rd, 32'h0, "unmapped address");
		bus_read(10'h218, rd);
		chk(rd, 32'h0, "neighbour index empty");
		$display("test refused done");
	endtask : test_refused

	// -------------------------------------------------------------------
	// Run control.
	// -------------------------------------------------------------------
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize

	initial begin
		reset_n = 1'b0;
		por_n = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = '0;
		byteenable = 4'h0;
		writedata = '0;
		irq_taken = 1'b0;
		serial_mode_bit_0 = 1'b0;
		framing_error_flag = 1'b0;
		tick(3);
		reset_n <= 1'b1;
		por_n <= 1'b1;
		tick(1);
		test_reset_values();
		test_flags();
		test_serial_view();
		test_resets();
		test_idle_irq();
		test_refused();
		summarize();
	end

	// The whole run needs about a hundred cycles, so this limit only trips on a hang.
	initial begin
		tick(5000);
		num_errors++;
		$display("Error at %0t: watchdog expired", $time);
		summarize();
	end
endmodule : pwrctl_top_tb
